// *** design/hbridge_drive_protection.sv ***
// h-bridge direction decode, fault protection and axi4-lite status/interrupt registers
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
module hbridge_drive_protection (
   input  wire                                i_mclk,
   input  wire                                i_rst,
   input  wire                                i_sleep_n,
   input  wire                                i_drive_ctl_a,
   input  wire                                i_drive_ctl_b,
   input  wire                                i_thermal_over,
   input  wire                                i_thermal_release,
   input  wire                                i_logic_under,
   input  wire                                i_logic_release,
   input  wire                                i_motor_supply_under,
   input  wire                                i_motor_supply_release,
   input  wire                                i_overcurrent,
   output logic                               o_bridge_out_a_hi,
   output logic                               o_bridge_out_a_lo,
   output logic                               o_bridge_out_b_hi,
   output logic                               o_bridge_out_b_lo,
   output logic                               o_irq,
   input  wire  [hbridge_pkg::ADDR_W-1:0]     i_awaddr,
   input  wire                                i_awvalid,
   output logic                               o_awready,
   input  wire  [31:0]                        i_wdata,
   input  wire  [3:0]                         i_wstrb,
   input  wire                                i_wvalid,
   output logic                               o_wready,
   output logic [1:0]                         o_bresp,
   output logic                               o_bvalid,
   input  wire                                i_bready,
   input  wire  [hbridge_pkg::ADDR_W-1:0]     i_araddr,
   input  wire                                i_arvalid,
   output logic                               o_arready,
   output logic [31:0]                        o_rdata,
   output logic [1:0]                         o_rresp,
   output logic                               o_rvalid,
   input  wire                                i_rready
);
   localparam int PIN_W = hbridge_pkg::PIN_W;
   localparam int EVT_W = hbridge_pkg::EVT_W;
   localparam int AW    = hbridge_pkg::ADDR_W;

   function automatic logic addr_is(input logic [AW-1:0] a, input logic [AW-1:0] off);
      return a[AW-1:2] == off[AW-1:2];
   endfunction

   // pin synchronisers
   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] pin_meta_reg;
   logic [PIN_W-1:0] pin_sync_reg;

   always_comb begin
      pin_raw                              = '0;
      pin_raw[hbridge_pkg::PIN_SLEEP]      = i_sleep_n;
      pin_raw[hbridge_pkg::PIN_CTL_A]      = i_drive_ctl_a;
      pin_raw[hbridge_pkg::PIN_CTL_B]      = i_drive_ctl_b;
      pin_raw[hbridge_pkg::PIN_THERM_OVER] = i_thermal_over;
      pin_raw[hbridge_pkg::PIN_THERM_REL]  = i_thermal_release;
      pin_raw[hbridge_pkg::PIN_VCC_UNDER]  = i_logic_under;
      pin_raw[hbridge_pkg::PIN_VCC_REL]    = i_logic_release;
      pin_raw[hbridge_pkg::PIN_MOT_UNDER]  = i_motor_supply_under;
      pin_raw[hbridge_pkg::PIN_MOT_REL]    = i_motor_supply_release;
      pin_raw[hbridge_pkg::PIN_OC]         = i_overcurrent;
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         pin_meta_reg <= '0;
         pin_sync_reg <= '0;
      end else begin
         pin_meta_reg <= pin_raw;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   wire sleep_s      = pin_sync_reg[hbridge_pkg::PIN_SLEEP];
   wire ctl_a_s      = pin_sync_reg[hbridge_pkg::PIN_CTL_A];
   wire ctl_b_s      = pin_sync_reg[hbridge_pkg::PIN_CTL_B];
   wire therm_over_s = pin_sync_reg[hbridge_pkg::PIN_THERM_OVER];
   wire therm_rel_s  = pin_sync_reg[hbridge_pkg::PIN_THERM_REL];
   wire vcc_under_s  = pin_sync_reg[hbridge_pkg::PIN_VCC_UNDER];
   wire vcc_rel_s    = pin_sync_reg[hbridge_pkg::PIN_VCC_REL];
   wire mot_under_s  = pin_sync_reg[hbridge_pkg::PIN_MOT_UNDER];
   wire mot_rel_s    = pin_sync_reg[hbridge_pkg::PIN_MOT_REL];
   wire oc_s         = pin_sync_reg[hbridge_pkg::PIN_OC];

   // over-current noise mask: the flag must stay high for the whole mask time
   logic [hbridge_pkg::CNT_W-1:0] oc_cnt_reg;
   logic [hbridge_pkg::CNT_W-1:0] oc_cnt_next;
   wire                           oc_hit;

   assign oc_hit      = oc_s && (oc_cnt_reg == hbridge_pkg::OC_MASK_LAST);
   assign oc_cnt_next = !oc_s ? '0 :
                        (oc_hit ? oc_cnt_reg : oc_cnt_reg + 1'b1);

   // fault locks; a set in the same cycle as a release wins
   logic [EVT_W-1:0] lock_reg;
   logic [EVT_W-1:0] lock_next;

   always_comb begin
      lock_next = lock_reg;
      lock_next[hbridge_pkg::LOCK_THERM] = therm_over_s |
         (lock_reg[hbridge_pkg::LOCK_THERM] & ~therm_rel_s);
      lock_next[hbridge_pkg::LOCK_OC] = oc_hit |
         (lock_reg[hbridge_pkg::LOCK_OC] & sleep_s);
      lock_next[hbridge_pkg::LOCK_VCC] = vcc_under_s |
         (lock_reg[hbridge_pkg::LOCK_VCC] & ~vcc_rel_s);
      lock_next[hbridge_pkg::LOCK_MOT] = mot_under_s |
         (lock_reg[hbridge_pkg::LOCK_MOT] & ~mot_rel_s);
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         oc_cnt_reg <= '0;
         lock_reg   <= '0;
      end else begin
         oc_cnt_reg <= oc_cnt_next;
         lock_reg   <= lock_next;
      end
   end

   // bridge mode decode
   hbridge_pkg::mode_t mode_w;
   wire                fault_w = |lock_reg;

   always_comb begin
      if (!sleep_s) mode_w = hbridge_pkg::MODE_STANDBY;
      else if (fault_w) mode_w = hbridge_pkg::MODE_STOP;
      else begin
         case ({ctl_a_s, ctl_b_s})
            2'b11:   mode_w = hbridge_pkg::MODE_BRAKE;
            2'b01:   mode_w = hbridge_pkg::MODE_FWD;
            2'b10:   mode_w = hbridge_pkg::MODE_REV;
            default: mode_w = hbridge_pkg::MODE_STOP;
         endcase
      end
   end

   hbridge_half u_half_a (
      .i_mclk    (i_mclk),
      .i_rst     (i_rst),
      .i_cmd     (hbridge_pkg::half_cmd(mode_w, 1'b0)),
      .o_gate_hi (o_bridge_out_a_hi),
      .o_gate_lo (o_bridge_out_a_lo)
   );

   hbridge_half u_half_b (
      .i_mclk    (i_mclk),
      .i_rst     (i_rst),
      .i_cmd     (hbridge_pkg::half_cmd(mode_w, 1'b1)),
      .o_gate_hi (o_bridge_out_b_hi),
      .o_gate_lo (o_bridge_out_b_lo)
   );

   wire gates_any = o_bridge_out_a_hi | o_bridge_out_a_lo | o_bridge_out_b_hi | o_bridge_out_b_lo;

   // axi4-lite write side
   logic              aw_held_reg;
   logic [AW-1:0]     awaddr_reg;
   logic              w_held_reg;
   logic [31:0]       wdata_reg;
   logic              wstrb0_reg;
   logic              bvalid_reg;
   logic [1:0]        bresp_reg;
   wire               wr_fire   = aw_held_reg & w_held_reg & ~bvalid_reg;
   wire               wr_en_hit = addr_is(awaddr_reg, hbridge_pkg::OFF_IRQ_EN);
   wire               wr_cl_hit = addr_is(awaddr_reg, hbridge_pkg::OFF_IRQ_CLR);
   wire               wr_ro_hit = addr_is(awaddr_reg, hbridge_pkg::OFF_STATUS) |
                                  addr_is(awaddr_reg, hbridge_pkg::OFF_IRQ_STAT);
   wire               wr_ok     = wr_en_hit | wr_cl_hit | wr_ro_hit;

   assign o_awready = ~aw_held_reg;
   assign o_wready  = ~w_held_reg;
   assign o_bvalid  = bvalid_reg;
   assign o_bresp   = bresp_reg;

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         aw_held_reg <= 1'b0;
         awaddr_reg  <= '0;
      end else if (i_awvalid && !aw_held_reg) begin
         aw_held_reg <= 1'b1;
         awaddr_reg  <= i_awaddr;
      end else if (wr_fire) begin
         aw_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         w_held_reg <= 1'b0;
         wdata_reg  <= '0;
         wstrb0_reg <= 1'b0;
      end else if (i_wvalid && !w_held_reg) begin
         w_held_reg <= 1'b1;
         wdata_reg  <= i_wdata;
         wstrb0_reg <= i_wstrb[0];
      end else if (wr_fire) begin
         w_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= hbridge_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= wr_ok ? hbridge_pkg::RESP_OKAY : hbridge_pkg::RESP_SLVERR;
      end else if (i_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // interrupt status, enable and write-one-to-clear
   logic [EVT_W-1:0] irq_stat_reg;
   logic [EVT_W-1:0] irq_en_reg;
   logic             irq_reg;
   wire  [EVT_W-1:0] evt_w     = lock_next & ~lock_reg;
   wire              wr_lane0  = wr_fire & wstrb0_reg;
   wire  [EVT_W-1:0] clr_w     = (wr_lane0 && wr_cl_hit) ? wdata_reg[EVT_W-1:0] : '0;
   wire  [EVT_W-1:0] stat_next = evt_w | (irq_stat_reg & ~clr_w);

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         irq_stat_reg <= '0;
         irq_en_reg   <= hbridge_pkg::IRQ_EN_RST;
         irq_reg      <= 1'b0;
      end else begin
         irq_stat_reg <= stat_next;
         irq_en_reg   <= (wr_lane0 && wr_en_hit) ? wdata_reg[EVT_W-1:0] : irq_en_reg;
         irq_reg      <= |(stat_next & ((wr_lane0 && wr_en_hit) ?
                                        wdata_reg[EVT_W-1:0] : irq_en_reg));
      end
   end

   assign o_irq = irq_reg;

   // axi4-lite read side
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;
   logic [31:0] rd_mux;
   logic        rd_ok;

   assign o_arready = ~rvalid_reg;
   assign o_rvalid  = rvalid_reg;
   assign o_rdata   = rdata_reg;
   assign o_rresp   = rresp_reg;

   always_comb begin
      rd_mux = '0;
      rd_ok  = 1'b1;
      if (addr_is(i_araddr, hbridge_pkg::OFF_STATUS)) begin
         rd_mux[EVT_W-1:0] = lock_reg;
         rd_mux[hbridge_pkg::MODE_LSB +: 3] = mode_w;
      end else if (addr_is(i_araddr, hbridge_pkg::OFF_IRQ_STAT)) begin
         rd_mux[EVT_W-1:0] = irq_stat_reg;
      end else if (addr_is(i_araddr, hbridge_pkg::OFF_IRQ_EN)) begin
         rd_mux[EVT_W-1:0] = irq_en_reg;
      end else if (!addr_is(i_araddr, hbridge_pkg::OFF_IRQ_CLR)) begin
         rd_ok = 1'b0;
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= '0;
         rresp_reg  <= hbridge_pkg::RESP_OKAY;
      end else if (i_arvalid && !rvalid_reg) begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= rd_mux;
         rresp_reg  <= rd_ok ? hbridge_pkg::RESP_OKAY : hbridge_pkg::RESP_SLVERR;
      end else if (i_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // checks
   localparam int BRAKE_WAIT = hbridge_pkg::DEAD_CYC + 2;

   property p_therm_off;
      @(posedge i_mclk) disable iff (i_rst) lock_reg[hbridge_pkg::LOCK_THERM] |=> !gates_any;
   endproperty
   a_therm_off : assert property (p_therm_off) else $error("outputs on during thermal trip");

   property p_therm_rel;
      @(posedge i_mclk) disable iff (i_rst)
      lock_reg[hbridge_pkg::LOCK_THERM] && therm_rel_s && !therm_over_s
         |=> !lock_reg[hbridge_pkg::LOCK_THERM];
   endproperty
   a_therm_rel : assert property (p_therm_rel) else $error("thermal stop not released");

   property p_oc_mask;
      @(posedge i_mclk) disable iff (i_rst)
      $rose(lock_reg[hbridge_pkg::LOCK_OC]) |-> $past(oc_cnt_reg) == hbridge_pkg::OC_MASK_LAST;
   endproperty
   a_oc_mask : assert property (p_oc_mask) else $error("over-current trip before mask time");

   property p_oc_off;
      @(posedge i_mclk) disable iff (i_rst) lock_reg[hbridge_pkg::LOCK_OC] |=> !gates_any;
   endproperty
   a_oc_off : assert property (p_oc_off) else $error("outputs on during over-current stop");

   property p_oc_hold;
      @(posedge i_mclk) disable iff (i_rst)
      lock_reg[hbridge_pkg::LOCK_OC] && sleep_s |=> lock_reg[hbridge_pkg::LOCK_OC];
   endproperty
   a_oc_hold : assert property (p_oc_hold) else $error("over-current latch lost while awake");

   property p_supply_off;
      @(posedge i_mclk) disable iff (i_rst)
      lock_reg[hbridge_pkg::LOCK_VCC] || lock_reg[hbridge_pkg::LOCK_MOT] |=> !gates_any;
   endproperty
   a_supply_off : assert property (p_supply_off) else $error("outputs on in lockout");

   property p_supply_rel;
      @(posedge i_mclk) disable iff (i_rst)
      (lock_reg[hbridge_pkg::LOCK_VCC] && vcc_rel_s && !vcc_under_s
         |=> !lock_reg[hbridge_pkg::LOCK_VCC]) and
      (lock_reg[hbridge_pkg::LOCK_MOT] && mot_rel_s && !mot_under_s
         |=> !lock_reg[hbridge_pkg::LOCK_MOT]);
   endproperty
   a_supply_rel : assert property (p_supply_rel) else $error("lockout not released");

   property p_brake;
      @(posedge i_mclk) disable iff (i_rst)
      (mode_w == hbridge_pkg::MODE_BRAKE) [*2] |-> ##[0:BRAKE_WAIT]
      ((o_bridge_out_a_lo && o_bridge_out_b_lo) || (mode_w != hbridge_pkg::MODE_BRAKE));
   endproperty
   a_brake : assert property (p_brake) else $error("brake did not pull both outputs low");

   property p_fwd;
      @(posedge i_mclk) disable iff (i_rst)
      mode_w == hbridge_pkg::MODE_FWD |=> !o_bridge_out_a_hi && !o_bridge_out_b_lo;
   endproperty
   a_fwd : assert property (p_fwd) else $error("wrong polarity in forward drive");

   property p_standby;
      @(posedge i_mclk) disable iff (i_rst) !sleep_s |=> !gates_any;
   endproperty
   a_standby : assert property (p_standby) else $error("outputs on in standby");

   c_fwd_drive : cover property (@(posedge i_mclk) disable iff (i_rst)
      o_bridge_out_a_lo && o_bridge_out_b_hi);
   c_oc_trip : cover property (@(posedge i_mclk) disable iff (i_rst)
      $rose(lock_reg[hbridge_pkg::LOCK_OC]));
   c_irq : cover property (@(posedge i_mclk) disable iff (i_rst) $rose(o_irq));

endmodule // hbridge_drive_protection

// *** pkg/hbridge_pkg.sv ***
// package: constants, types and decode helpers for the h-bridge drive protection block
// What this block does
// - dead time between upper and lower switches
// - over-temperature turns every output off
// - thermal trip holds stop, outputs high impedance
// - thermal stop releases after hysteresis cooling
// - over-current turns every output off
// - over-current must persist for masking time
// - over-current trip enters stop mode
// - over-current latch cleared by power or standby
// - logic supply lockout forces stop
// - logic lockout releases above higher threshold
// - motor supply lockout forces stop
// - motor lockout releases above higher threshold
package hbridge_pkg;

   // timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int DEAD_TIME_NS  = 200;
   localparam int OC_MASK_NS    = 4000;
   localparam int DEAD_CYC      = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OC_MASK_CYC   = (OC_MASK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W         = 8;
   localparam logic [CNT_W-1:0] DEAD_DONE    = CNT_W'(DEAD_CYC);
   localparam logic [CNT_W-1:0] OC_MASK_LAST = CNT_W'(OC_MASK_CYC - 1);

   // synchronised pin vector positions
   localparam int PIN_SLEEP      = 0;
   localparam int PIN_CTL_A      = 1;
   localparam int PIN_CTL_B      = 2;
   localparam int PIN_THERM_OVER = 3;
   localparam int PIN_THERM_REL  = 4;
   localparam int PIN_VCC_UNDER  = 5;
   localparam int PIN_VCC_REL    = 6;
   localparam int PIN_MOT_UNDER  = 7;
   localparam int PIN_MOT_REL    = 8;
   localparam int PIN_OC         = 9;
   localparam int PIN_W          = 10;

   // lock / event bit positions (status, irq status, enable, clear share them)
   localparam int LOCK_THERM = 0;
   localparam int LOCK_OC    = 1;
   localparam int LOCK_VCC   = 2;
   localparam int LOCK_MOT   = 3;
   localparam int EVT_W      = 4;
   localparam int MODE_LSB   = 4;

   // register map
   localparam int ADDR_W = 5;
   localparam logic [ADDR_W-1:0] OFF_STATUS   = 5'h00;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 5'h04;
   localparam logic [ADDR_W-1:0] OFF_IRQ_EN   = 5'h08;
   localparam logic [ADDR_W-1:0] OFF_IRQ_CLR  = 5'h0C;
   localparam logic [EVT_W-1:0]  IRQ_EN_RST   = 4'h0;
   localparam logic [1:0]        RESP_OKAY    = 2'h0;
   localparam logic [1:0]        RESP_SLVERR  = 2'h2;

   typedef enum logic [1:0] {HB_OFF, HB_HIGH, HB_LOW} hb_cmd_t;
   typedef enum logic [2:0] {MODE_STANDBY, MODE_STOP, MODE_FWD, MODE_REV, MODE_BRAKE} mode_t;

   // per half-bridge command for a bridge mode
   function automatic hb_cmd_t half_cmd(input mode_t m, input logic side_b);
      case (m)
         MODE_BRAKE: return HB_LOW;
         MODE_FWD:   return side_b ? HB_HIGH : HB_LOW;
         MODE_REV:   return side_b ? HB_LOW : HB_HIGH;
         default:    return HB_OFF;
      endcase
   endfunction

endpackage

// *** design/hbridge_half.sv ***
// one half-bridge switch sequencer with enforced dead time
`timescale 1ns/10ps
module hbridge_half (
   input  wire                     i_mclk,
   input  wire                     i_rst,
   input  wire hbridge_pkg::hb_cmd_t i_cmd,
   output logic                    o_gate_hi,
   output logic                    o_gate_lo
);
   typedef enum logic [1:0] {ST_OFF, ST_HIGH, ST_LOW} hb_state_t;

   hb_state_t                         state_reg;
   hb_state_t                         state_next;
   logic [hbridge_pkg::CNT_W-1:0]     gap_reg;
   logic [hbridge_pkg::CNT_W-1:0]     gap_next;
   wire                               gap_done;

   assign gap_done = (gap_reg >= hbridge_pkg::DEAD_DONE);

   // a switch may only turn on after both have been off for the dead time
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_OFF: begin
            if (gap_done && i_cmd == hbridge_pkg::HB_HIGH) state_next = ST_HIGH;
            else if (gap_done && i_cmd == hbridge_pkg::HB_LOW) state_next = ST_LOW;
         end
         ST_HIGH: state_next = (i_cmd == hbridge_pkg::HB_HIGH) ? ST_HIGH : ST_OFF;
         ST_LOW:  state_next = (i_cmd == hbridge_pkg::HB_LOW) ? ST_LOW : ST_OFF;
         default: state_next = ST_OFF;
      endcase
   end

   assign gap_next = (state_reg != ST_OFF) ? '0 :
                     (gap_done ? gap_reg : gap_reg + 1'b1);

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         state_reg <= ST_OFF;
         gap_reg   <= hbridge_pkg::DEAD_DONE;
      end else begin
         state_reg <= state_next;
         gap_reg   <= gap_next;
      end
   end

   assign o_gate_hi = (state_reg == ST_HIGH);
   assign o_gate_lo = (state_reg == ST_LOW);

   property p_dead_lo;
      @(posedge i_mclk) disable iff (i_rst)
      $rose(o_gate_lo) |-> $past(gap_reg) == hbridge_pkg::DEAD_DONE && !$past(o_gate_hi);
   endproperty
   a_dead_lo : assert property (p_dead_lo) else $error("low switch on without dead time");

   property p_dead_hi;
      @(posedge i_mclk) disable iff (i_rst)
      $rose(o_gate_hi) |-> $past(gap_reg) == hbridge_pkg::DEAD_DONE && !$past(o_gate_lo);
   endproperty
   a_dead_hi : assert property (p_dead_hi) else $error("high switch on without dead time");

endmodule // hbridge_half

// *** tb/hbridge_ctl_model.sv ***
// controller model that drives the standby and direction pins
`timescale 1ns/10ps
module hbridge_ctl_model (
   input  wire        i_mclk,
   input  wire  [2:0] i_mode,
   input  wire        i_quiet,
   output logic       o_sleep_n,
   output logic       o_ctl_a,
   output logic       o_ctl_b
);
   initial begin
      o_sleep_n = 1'b0;
      o_ctl_a   = 1'b0;
      o_ctl_b   = 1'b0;
   end
   // mode 0 standby, 1 stop, 2 forward, 3 reverse, 4 brake; quiet holds every pin low
   always @(posedge i_mclk) begin
      o_sleep_n <= !i_quiet && i_mode != 3'h0;
      o_ctl_a   <= !i_quiet && (i_mode == 3'h3 || i_mode == 3'h4);
      o_ctl_b   <= !i_quiet && (i_mode == 3'h2 || i_mode == 3'h4);
   end
endmodule // hbridge_ctl_model

// *** tb/testbench.sv ***
// self-checking bench for the h-bridge drive protection block
`timescale 1ns/10ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin failures++; \
   $display("mismatch %s expected %h seen %h", n, e, s); end end
module testbench;
   logic        mclk, rst = 1'b1, quiet = 1'b1, irq;
   logic [2:0]  mode = 3'h0;
   logic [6:0]  fp = 7'h2A;
   logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, sleep_n, ca, cb;
   logic [1:0]  bresp, rresp;
   logic [3:0]  gates, lk = 4'h0;
   int          cm = 0, lb, off_a = 100, failures = 0, num_checks = 0;

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   hbridge_ctl_model hbridge_ctl_model_inst (.i_mclk(mclk), .i_mode(mode), .i_quiet(quiet),
      .o_sleep_n(sleep_n), .o_ctl_a(ca), .o_ctl_b(cb));

   hbridge_drive_protection hbridge_drive_protection_inst (.i_mclk(mclk), .i_rst(rst),
      .i_sleep_n(sleep_n), .i_drive_ctl_a(ca), .i_drive_ctl_b(cb),
      .i_thermal_over(fp[0]), .i_thermal_release(fp[1]), .i_logic_under(fp[2]),
      .i_logic_release(fp[3]), .i_motor_supply_under(fp[4]),
      .i_motor_supply_release(fp[5]), .i_overcurrent(fp[6]),
      .o_bridge_out_a_hi(gates[3]), .o_bridge_out_a_lo(gates[2]),
      .o_bridge_out_b_hi(gates[1]), .o_bridge_out_b_lo(gates[0]), .o_irq(irq),
      .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
      .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
      .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
      .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
      .i_rready(rready));

   // watch for shoot-through and for the half-A high switch turned on too soon
   always @(negedge mclk) begin
      if (!rst) begin
         `CHK("cross", 1'b0, (gates[3] & gates[2]) | (gates[1] & gates[0]))
         if ($rose(gates[3])) `CHK("dead", 1'b1, off_a >= 10)
      end
      off_a <= (gates[3] || gates[2]) ? 0 : off_a + 1;
   end

   function automatic logic [3:0] exp_g(int m);
      if (lk != 4'h0) return 4'h0;
      case (m)
         2: return 4'b0110;
         3: return 4'b1001;
         4: return 4'b0101;
         default: return 4'h0;
      endcase
   endfunction

   task automatic finish_test();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic step(int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic bus(input bit rd, input logic [4:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic [1:0] r);
      bit ta, tw, tb;
      int k;
      @(posedge mclk);
      if (rd) begin
         araddr  <= a;
         arvalid <= 1'b1;
         rready  <= 1'b1;
      end else begin
         awaddr  <= a;
         wdata   <= d;
         awvalid <= 1'b1;
         wvalid  <= 1'b1;
         bready  <= 1'b1;
      end
      for (k = 0; k < 50; k++) begin
         @(negedge mclk);
         ta = rd ? arready : awready;
         tw = wready;
         tb = rd ? rvalid : bvalid;
         q  = rdata;
         r  = rd ? rresp : bresp;
         @(posedge mclk);
         if (ta && rd) arvalid <= 1'b0;
         if (ta && !rd) awvalid <= 1'b0;
         if (tw && !rd) wvalid <= 1'b0;
         if (tb) begin
            rready <= 1'b0;
            bready <= 1'b0;
            break;
         end
      end
      if (k == 50) begin
         failures++;
         finish_test();
      end
   endtask

   task automatic chk();
      logic [31:0] q;
      logic [1:0]  r;
      step(30);
      `CHK("gates", exp_g(cm), gates)
      bus(1, 5'h00, 32'h0, q, r);
      `CHK("status_locks", {28'h0, lk}, q & 32'hF)
      `CHK("status_rresp", hbridge_pkg::RESP_OKAY, r)
      `CHK("status_mode", (cm != 0 && lk != 4'h0) ? 3'h1 : 3'(cm), q[6:4])
   endtask

   task automatic setm(int m);
      @(posedge mclk);
      mode <= m[2:0];
      cm = m;
      if (m == 0) lk[1] = 1'b0;
      chk();
   endtask

   task automatic pin(int i, bit v, int n);
      @(posedge mclk);
      fp[i] <= v;
      step(n);
   endtask

   initial begin
      logic [31:0] q;
      logic [1:0]  r;
      int          s;
      s = $urandom(25);
      repeat (12) @(posedge mclk);
      rst   <= 1'b0;
      quiet <= 1'b0;
      bus(1, 5'h08, 32'h0, q, r);
      `CHK("irq_en_reset", 32'h0, q)
      for (int i = 0; i < 14; i++) setm(i < 5 ? i : $urandom % 5);
      bus(0, 5'h08, 32'hF, q, r);
      setm(2);
      for (int j = 0; j < 3; j++) begin
         lb = (j == 0) ? 0 : j + 1;
         pin(2 * j + 1, 1'b0, 0);
         pin(2 * j, 1'b1, 0);
         lk[lb] = 1'b1;
         chk();
         `CHK("irq_set", 1'b1, irq)
         bus(0, 5'h0C, 32'hF, q, r);
         `CHK("clear_bresp", hbridge_pkg::RESP_OKAY, r)
         step(3);
         `CHK("irq_cleared", 1'b0, irq)
         pin(2 * j, 1'b0, 0);
         chk();
         pin(2 * j + 1, 1'b1, 0);
         lk[lb] = 1'b0;
         chk();
      end
      bus(0, 5'h08, 32'h0, q, r);
      pin(6, 1'b1, $urandom % 150);
      pin(6, 1'b0, 5);
      pin(6, 1'b1, 198);
      pin(6, 1'b0, 0);
      chk();
      pin(6, 1'b1, 230);
      lk[1] = 1'b1;
      chk();
      `CHK("irq_masked", 1'b0, irq)
      pin(6, 1'b0, 0);
      chk();
      setm(0);
      setm(2);
      bus(1, 5'h10, 32'h0, q, r);
      `CHK("unmapped_rresp", hbridge_pkg::RESP_SLVERR, r)
      `CHK("unmapped_rdata", 32'h0, q)
      bus(0, 5'h1C, 32'hF, q, r);
      `CHK("unmapped_bresp", hbridge_pkg::RESP_SLVERR, r)
      bus(1, 5'h0C, 32'h0, q, r);
      `CHK("clear_reads_zero", 32'h0, q)
      finish_test();
   end
endmodule // testbench
